// ===== core/fec_core.sv
// frame sequencing, readout window and exposure control with apb registers
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
// How it works
// - frame-synced writes take effect on the frame after the next end of frame valid
// - snapshot writes after frame valid, before trigger, apply next frame
// - rolling snapshot trigger during frame valid keeps one-frame-later timing
// - hold bit stores brightness writes; clearing applies them next frame
// - other fields take effect as soon as the write completes
// - restart bit 0 aborts the current frame at once
// - restart applies pending window and width; held values stay pending
// - current row plus one more row finish before the new frame
// - pause bit halts after restart, outside snapshot mode only, until software clears it
// - host keeps restart 1 when clearing pause; device clears restart
// - window from start fields, size fields plus one, default 1440x1080
// - unmirrored output is row-major ascending rows and columns
// - column and row mirror reverse active order independently
// - rolling: release scan, then read scan; exposure between them
// - all rows reset 16x1096 array clocks after reset or rolling entry
// - global release frees all rows at once; reset follows each readout
// - rolling exposure is width rows times row time minus 2x delay
// - bulb exposure from trigger width; rolling whole rows, global exact
// - shutter select set gives global release, clear gives rolling
module fec_core
  import fec_pkg::*;
#(
  parameter int ALL_RESET_CYCLES = ALL_RESET_CYC
)(
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TRIGGER,
  output logic FRAME_VALID,
  output logic LINE_VALID,
  output logic [11:0] PIX_ROW,
  output logic [11:0] PIX_COL,
  output logic ALL_ROWS_RESET,
  output logic SHUT_ROW_VLD,
  output logic [11:0] SHUT_ROW,
  output logic [7:0] GAIN
);
  // ==========================================================
  // helpers
  function automatic logic [12:0] row_time(input logic [11:0] csize);
    row_time = 13'({1'b0, csize}) + 13'h0001 + HBLANK_CYC;
  endfunction : row_time

  function automatic logic [31:0] exp_cycles(input logic [15:0] sw,
      input logic [12:0] rt, input logic [11:0] sd);
    logic [31:0] full;
    logic [31:0] ovh;
    full = 32'(sw) * 32'(rt);
    ovh = 32'({sd, 1'b0});
    exp_cycles = (full > ovh + 32'h1) ? full - ovh : 32'h1;
  endfunction : exp_cycles

  function automatic logic [11:0] win_addr(input logic [11:0] start,
      input logic [11:0] size, input logic [11:0] idx, input logic mir);
    win_addr = mir ? start + size - idx : start + idx;
  endfunction : win_addr

  // ==========================================================
  // declarations
  fec_upd_if upd ();
  fec_state_type state_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [11:0] col_start_ff, row_start_ff, col_size_ff, row_size_ff;
  logic [15:0] width_ff;
  logic [11:0] delay_ff;
  logic [7:0] gain_ff;
  logic pready_ff, pslverr_ff, trig_pend_ff, need_allrst_ff;
  logic restart_req_ff, trig_seen_ff;
  logic [31:0] prdata_ff, cnt_ff;
  logic [12:0] rt_cnt_ff, sh_cnt_ff;
  logic [11:0] rd_row_ff, sh_row_ff;
  logic [1:0] drain_ff;
  logic wr_en, acc_new, addr_ok, trig_now, row_end, global_reset_release, snap, bulb;
  logic go_frame, in_restart, enter_drain, apply_now;
  logic [12:0] rt;
  logic [31:0] exp_len;
  fec_state_type nxt_state;
  logic [CTRL_W-1:0] wctrl;

  assign global_reset_release = ctrl_ff[CB_GRR];
  assign snap = ctrl_ff[CB_SNAPSHOT];
  assign bulb = ctrl_ff[CB_BULB] && snap;
  assign rt = row_time(upd.act_win.col_size);
  assign exp_len = exp_cycles(upd.act_win.width_rows, rt, delay_ff);
  // >= so a row time that shrinks on restart cannot miss the row end
  assign row_end = rt_cnt_ff >= rt - 13'h0001;
  assign trig_now = TRIGGER || trig_pend_ff;
  assign wctrl = PWDATA[CTRL_W-1:0];

  // ==========================================================
  // apb slave: one wait state, write lands on the edge that sees pready
  assign acc_new = PSEL && PENABLE && !pready_ff;
  assign wr_en = PSEL && PENABLE && PWRITE && pready_ff && !pslverr_ff;
  assign addr_ok = PADDR[1:0] == 2'b00 && PADDR <= ADDR_TRIGGER;

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= acc_new;
      pslverr_ff <= acc_new && !addr_ok;
      if (acc_new && !PWRITE) begin
        case (PADDR)
          ADDR_CTRL: prdata_ff <= 32'(ctrl_ff);
          ADDR_COL_START: prdata_ff <= 32'(col_start_ff);
          ADDR_ROW_START: prdata_ff <= 32'(row_start_ff);
          ADDR_COL_SIZE: prdata_ff <= 32'(col_size_ff);
          ADDR_ROW_SIZE: prdata_ff <= 32'(row_size_ff);
          ADDR_EXP_WIDTH: prdata_ff <= 32'(width_ff);
          ADDR_FINE_DELAY: prdata_ff <= 32'(delay_ff);
          ADDR_GAIN: prdata_ff <= 32'(gain_ff);
          ADDR_STATUS: prdata_ff <= {16'h0, rd_row_ff, need_allrst_ff,
                                     3'(state_ff)};
          default: prdata_ff <= 32'h0;
        endcase
      end
    end
  end

  a_pready_one_cycle: assert property (
    @(posedge SYS_CLK) disable iff (SRST)
    PREADY |=> !PREADY)
    else $error("pready held longer than one cycle");

  // ==========================================================
  // software-visible fields; these are the pending values
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      col_start_ff <= COL_START_RST;
      row_start_ff <= ROW_START_RST;
      col_size_ff <= COL_SIZE_RST;
      row_size_ff <= ROW_SIZE_RST;
      width_ff <= EXP_WIDTH_RST;
      delay_ff <= FINE_DELAY_RST;
      gain_ff <= GAIN_RST;
    end else if (wr_en) begin
      case (PADDR)
        ADDR_COL_START: col_start_ff <= PWDATA[11:0];
        ADDR_ROW_START: row_start_ff <= PWDATA[11:0];
        ADDR_COL_SIZE: col_size_ff <= PWDATA[11:0];
        ADDR_ROW_SIZE: row_size_ff <= PWDATA[11:0];
        ADDR_EXP_WIDTH: width_ff <= PWDATA[15:0];
        ADDR_FINE_DELAY: delay_ff <= PWDATA[11:0];
        ADDR_GAIN: gain_ff <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // control: mode bits act at once; restart bit is cleared by hardware
  assign in_restart = state_ff == ST_DRAIN || state_ff == ST_PAUSE;
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_en && PADDR == ADDR_CTRL) begin
      ctrl_ff <= wctrl;
    end else if (in_restart && nxt_state != state_ff
                 && nxt_state != ST_PAUSE) begin
      ctrl_ff[CB_RESTART] <= 1'b0;
    end
  end

  // a new write wins over the pending hardware clear
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      restart_req_ff <= 1'b0;
    end else if (wr_en && PADDR == ADDR_CTRL && wctrl[CB_RESTART]) begin
      restart_req_ff <= 1'b1;
    end else if (enter_drain) begin
      restart_req_ff <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      need_allrst_ff <= 1'b1;
    end else if (wr_en && PADDR == ADDR_CTRL && !wctrl[CB_GRR]
                 && wctrl[CB_GRR+:2] != ctrl_ff[CB_GRR+:2]
                 || wr_en && PADDR == ADDR_CTRL && !wctrl[CB_GRR]
                 && wctrl[CB_SNAPSHOT] != ctrl_ff[CB_SNAPSHOT]) begin
      need_allrst_ff <= 1'b1;
    end else if (state_ff == ST_ALLRST && nxt_state != ST_ALLRST) begin
      need_allrst_ff <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      trig_pend_ff <= 1'b0;
    end else if (wr_en && PADDR == ADDR_TRIGGER && PWDATA[0]) begin
      trig_pend_ff <= 1'b1;
    end else if (go_frame) begin
      trig_pend_ff <= 1'b0;
    end
  end

  // trigger seen during frame valid in rolling snapshot
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      trig_seen_ff <= 1'b0;
    end else if (state_ff == ST_READ && snap && !global_reset_release && trig_now) begin
      trig_seen_ff <= 1'b1;
    end else if (go_frame) begin
      trig_seen_ff <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer
  assign go_frame = state_ff == ST_IDLE && !restart_req_ff
                    && !need_allrst_ff && (!snap || trig_now);
  assign enter_drain = restart_req_ff && state_ff != ST_ALLRST
                       && !in_restart;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_ALLRST:
        if (cnt_ff >= 32'(ALL_RESET_CYCLES - 1)) nxt_state = ST_IDLE;
      ST_IDLE:
        // a mode change made while idle still gets its reset first
        if (need_allrst_ff) nxt_state = ST_ALLRST;
        else if (go_frame) nxt_state = ST_EXPOSE;
      ST_EXPOSE:
        if (bulb && global_reset_release && !trig_now) nxt_state = ST_READ;
        else if (bulb && !global_reset_release && !trig_now && row_end)
          nxt_state = ST_READ;
        else if (!bulb && cnt_ff >= exp_len - 32'h1)
          nxt_state = ST_READ;
      ST_READ:
        if (row_end && rd_row_ff == upd.act_win.row_size)
          nxt_state = ST_VBLANK;
      ST_VBLANK:
        if (row_end && cnt_ff[11:0] == VBLANK_ROWS - 12'h001)
          nxt_state = (global_reset_release || need_allrst_ff) ? ST_ALLRST : ST_IDLE;
      ST_DRAIN:
        if (row_end && drain_ff == 2'd1)
          nxt_state = (ctrl_ff[CB_PAUSE] && !snap) ? ST_PAUSE
                      : (need_allrst_ff || global_reset_release) ? ST_ALLRST : ST_IDLE;
      ST_PAUSE:
        if (!ctrl_ff[CB_PAUSE])
          nxt_state = (need_allrst_ff || global_reset_release) ? ST_ALLRST : ST_IDLE;
      default: nxt_state = ST_ALLRST;
    endcase
    if (enter_drain) nxt_state = ST_DRAIN;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) state_ff <= ST_ALLRST;
    else state_ff <= nxt_state;
  end

  // general counter: reset cycles, exposure cycles, blanking rows
  always_ff @(posedge SYS_CLK) begin
    if (SRST || nxt_state != state_ff) cnt_ff <= 32'h0;
    else if (state_ff == ST_VBLANK) cnt_ff <= cnt_ff + 32'(row_end);
    else cnt_ff <= cnt_ff + 32'h1;
  end

  // row timer restarts on frame and readout entry
  always_ff @(posedge SYS_CLK) begin
    if (SRST || row_end
        || (nxt_state != state_ff && nxt_state != ST_DRAIN))
      rt_cnt_ff <= 13'h0;
    else rt_cnt_ff <= rt_cnt_ff + 13'h0001;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST || state_ff != ST_DRAIN) drain_ff <= 2'd0;
    else if (row_end) drain_ff <= drain_ff + 2'd1;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST || state_ff != ST_READ) rd_row_ff <= 12'h0;
    else if (row_end) rd_row_ff <= rd_row_ff + 12'h001;
  end

  // ==========================================================
  // update points: end of frame valid, snapshot trigger, restart
  assign apply_now = (state_ff == ST_READ && nxt_state == ST_VBLANK)
                     || (go_frame && snap && !trig_seen_ff)
                     || enter_drain;
  assign upd.apply = apply_now;
  assign upd.hold = ctrl_ff[CB_HOLD];
  assign upd.pend_win = '{col_start_ff, row_start_ff, col_size_ff,
                          row_size_ff, ctrl_ff[CB_MIR_COL],
                          ctrl_ff[CB_MIR_ROW], width_ff};
  assign upd.pend_gain = gain_ff;

  fec_shadow u_shadow (
    .clk (SYS_CLK),
    .srst (SRST),
    .upd (upd)
  );

  // ==========================================================
  // release scan: rolling only, one row per row time from exposure start
  always_ff @(posedge SYS_CLK) begin
    if (SRST || state_ff == ST_IDLE) begin
      sh_cnt_ff <= 13'h0;
      sh_row_ff <= 12'h0;
    end else if (state_ff == ST_EXPOSE || state_ff == ST_READ) begin
      sh_cnt_ff <= (sh_cnt_ff >= rt - 13'h0001) ? 13'h0
                   : sh_cnt_ff + 13'h0001;
      if (sh_cnt_ff >= rt - 13'h0001) sh_row_ff <= sh_row_ff + 12'h001;
    end
  end

  // ==========================================================
  // pin outputs
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      FRAME_VALID <= 1'b0;
      LINE_VALID <= 1'b0;
      PIX_ROW <= 12'h0;
      PIX_COL <= 12'h0;
      ALL_ROWS_RESET <= 1'b1;
      SHUT_ROW_VLD <= 1'b0;
      SHUT_ROW <= 12'h0;
    end else begin
      FRAME_VALID <= state_ff == ST_READ;
      LINE_VALID <= state_ff == ST_READ
                    && rt_cnt_ff <= 13'(upd.act_win.col_size);
      PIX_ROW <= win_addr(upd.act_win.row_start, upd.act_win.row_size,
                          rd_row_ff, upd.act_win.mir_row);
      PIX_COL <= win_addr(upd.act_win.col_start, upd.act_win.col_size,
                          rt_cnt_ff[11:0], upd.act_win.mir_col);
      // global mode keeps every row in reset until the frame starts
      ALL_ROWS_RESET <= state_ff == ST_ALLRST
                        || (global_reset_release && state_ff == ST_IDLE);
      SHUT_ROW_VLD <= !global_reset_release && sh_cnt_ff == 13'h0
                      && sh_row_ff <= upd.act_win.row_size
                      && (state_ff == ST_EXPOSE
                          || state_ff == ST_READ);
      SHUT_ROW <= upd.act_win.row_start + sh_row_ff;
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign GAIN = upd.act_gain;

  // ==========================================================
  // checks
  a_allrst_length: assert property (
    @(posedge SYS_CLK) disable iff (SRST)
    state_ff == ST_ALLRST && nxt_state == ST_IDLE
    |-> cnt_ff == 32'(ALL_RESET_CYCLES - 1))
    else $error("all-rows reset left early");

  a_grr_reset_follows: assert property (
    @(posedge SYS_CLK) disable iff (SRST)
    global_reset_release && state_ff == ST_VBLANK && nxt_state != ST_VBLANK
    && !enter_drain |=> state_ff == ST_ALLRST)
    else $error("global mode skipped the all-rows reset");

  a_fv_tracks_read: assert property (
    @(posedge SYS_CLK) disable iff (SRST)
    state_ff == ST_READ |=> FRAME_VALID)
    else $error("frame valid low during readout");

  a_lv_inside_fv: assert property (
    @(posedge SYS_CLK) disable iff (SRST)
    LINE_VALID |-> FRAME_VALID)
    else $error("line valid outside frame valid");

  a_restart_aborts: assert property (
    @(posedge SYS_CLK) disable iff (SRST)
    restart_req_ff && state_ff == ST_READ |=> state_ff == ST_DRAIN
    ##1 !FRAME_VALID)
    else $error("restart did not abort the frame");

  sequence s_pause_entered;
    state_ff == ST_DRAIN ##1 state_ff == ST_PAUSE;
  endsequence

  a_pause_holds: assert property (
    @(posedge SYS_CLK) disable iff (SRST)
    s_pause_entered ##0 (ctrl_ff[CB_PAUSE] && !restart_req_ff)
    |=> state_ff == ST_PAUSE)
    else $error("pause released while bit still set");

  a_restart_self_clear: assert property (
    @(posedge SYS_CLK) disable iff (SRST)
    state_ff == ST_PAUSE && !ctrl_ff[CB_PAUSE] && !wr_en
    |=> !ctrl_ff[CB_RESTART])
    else $error("restart bit not cleared after resume");

  a_exposure_length: assert property (
    @(posedge SYS_CLK) disable iff (SRST)
    state_ff == ST_EXPOSE && nxt_state == ST_READ && !bulb
    && !enter_drain |-> cnt_ff == exp_len - 32'h1)
    else $error("exposure length wrong");

  a_drain_two_rows: assert property (
    @(posedge SYS_CLK) disable iff (SRST)
    state_ff == ST_DRAIN && nxt_state != ST_DRAIN
    |-> row_end && drain_ff == 2'd1)
    else $error("restart left before two row ends");
endmodule : fec_core

// ===== common/fec_pkg.sv
// shared constants and types of the frame and exposure control core
package fec_pkg;
  // ==========================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COL_START = 8'h04;
  localparam logic [7:0] ADDR_ROW_START = 8'h08;
  localparam logic [7:0] ADDR_COL_SIZE = 8'h0C;
  localparam logic [7:0] ADDR_ROW_SIZE = 8'h10;
  localparam logic [7:0] ADDR_EXP_WIDTH = 8'h14;
  localparam logic [7:0] ADDR_FINE_DELAY = 8'h18;
  localparam logic [7:0] ADDR_GAIN = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_TRIGGER = 8'h24;
  // ==========================================================
  // control register bit positions
  localparam int CB_RESTART = 0;
  localparam int CB_PAUSE = 1;
  localparam int CB_HOLD = 2;
  localparam int CB_SNAPSHOT = 3;
  localparam int CB_GRR = 4;
  localparam int CB_BULB = 5;
  localparam int CB_MIR_COL = 6;
  localparam int CB_MIR_ROW = 7;
  localparam int CTRL_W = 8;
  // ==========================================================
  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [11:0] COL_START_RST = 12'h010;
  localparam logic [11:0] ROW_START_RST = 12'h00C;
  localparam logic [11:0] COL_SIZE_RST = 12'h59F;
  localparam logic [11:0] ROW_SIZE_RST = 12'h437;
  localparam logic [15:0] EXP_WIDTH_RST = 16'h0010;
  localparam logic [11:0] FINE_DELAY_RST = 12'h000;
  localparam logic [7:0] GAIN_RST = 8'h10;
  // ==========================================================
  // timing
  localparam int ALL_RESET_ROWS = 16;
  localparam int ALL_RESET_ACLK = 1096;
  localparam int PIX_PER_ACLK = 2;
  localparam int ALL_RESET_CYC = ALL_RESET_ROWS * ALL_RESET_ACLK
                                 * PIX_PER_ACLK;
  localparam logic [12:0] HBLANK_CYC = 13'h0010;
  localparam logic [11:0] VBLANK_ROWS = 12'h008;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_ALLRST, ST_IDLE, ST_EXPOSE, ST_READ, ST_VBLANK, ST_DRAIN, ST_PAUSE
  } fec_state_type;

  typedef struct packed {
    logic [11:0] col_start;
    logic [11:0] row_start;
    logic [11:0] col_size;
    logic [11:0] row_size;
    logic mir_col;
    logic mir_row;
    logic [15:0] width_rows;
  } fec_win_type;
endpackage : fec_pkg

// ===== common/fec_upd_if.sv
// carrier between the sequencer and its frame-synchronised shadow copies
`timescale 1ns/1ps
interface fec_upd_if;
  import fec_pkg::*;
  fec_win_type pend_win;
  fec_win_type act_win;
  logic [7:0] pend_gain;
  logic [7:0] act_gain;
  logic apply;
  logic hold;
  modport ctl (output pend_win, pend_gain, apply, hold,
               input act_win, act_gain);
  modport shd (input pend_win, pend_gain, apply, hold,
               output act_win, act_gain);
endinterface : fec_upd_if

// ===== core/fec_shadow.sv
// active copies of frame-synchronised and held fields
`timescale 1ns/1ps
module fec_shadow
  import fec_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  fec_upd_if.shd upd
);
  // ==========================================================
  // window, mirror and exposure width
  always_ff @(posedge clk) begin
    if (srst) begin
      upd.act_win <= '{COL_START_RST, ROW_START_RST, COL_SIZE_RST,
                       ROW_SIZE_RST, 1'b0, 1'b0, EXP_WIDTH_RST};
    end else if (upd.apply) begin
      upd.act_win <= upd.pend_win;
    end
  end

  // ==========================================================
  // brightness: kept back while hold is set, even across a restart
  always_ff @(posedge clk) begin
    if (srst) begin
      upd.act_gain <= GAIN_RST;
    end else if (upd.apply && !upd.hold) begin
      upd.act_gain <= upd.pend_gain;
    end
  end

  a_hold_freezes_gain: assert property (
    @(posedge clk) disable iff (srst)
    upd.hold |=> $stable(upd.act_gain))
    else $error("gain changed while hold set");

  a_no_apply_stable: assert property (
    @(posedge clk) disable iff (srst)
    !upd.apply |=> $stable(upd.act_win))
    else $error("window changed without apply");
endmodule : fec_shadow

// ===== tb/fec_host_model.sv
// host side model: watches frame and line valid, reports frame geometry
`timescale 1ns/1ps
module fec_host_model (
  input wire logic clk,
  input wire logic fv,
  input wire logic lv,
  input wire logic [11:0] row,
  input wire logic [11:0] col,
  input wire logic arm,
  output logic trig,
  output int lines,
  output int pix,
  output logic [11:0] frow,
  output logic [11:0] fcol
);
  int l_cnt = 0;
  int p_cnt = 0;
  logic fv_d = 1'b0;
  logic lv_d = 1'b0;
  // trigger pin follows the bench's request one clock later
  always @(posedge clk) trig <= arm;
  // ==========================================================
  // geometry of the last completed frame
  always @(posedge clk) begin
    if (fv && !fv_d) begin
      l_cnt = 0;
      p_cnt = 0;
    end
    if (lv && !lv_d) begin
      if (l_cnt == 0) begin
        frow <= row;
        fcol <= col;
      end
      l_cnt = l_cnt + 1;
    end
    if (lv && l_cnt == 1) p_cnt = p_cnt + 1;
    if (!fv && fv_d) begin
      lines <= l_cnt;
      pix <= p_cnt;
    end
    fv_d = fv;
    lv_d = lv;
  end
endmodule : fec_host_model

// ===== tb/fec_core_tb_top.sv
// self-checking bench of the frame and exposure control core
`timescale 1ns/1ps
module fec_core_tb_top;
  import fec_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, trig, fv, lv, allrst, err, svld;
  logic arm = 1'b0;
  logic [11:0] prow, pcol, frow, fcol, srow;
  logic [7:0] gain, g;
  logic [31:0] exp_reg [0:15];
  int lines, pix, nexp;
  int n_fail = 0;
  int check_count = 0;
  int seed = 32'h16B4;

  always #2 sys_clk = ~sys_clk;

  fec_core #(.ALL_RESET_CYCLES(64)) fec_core_inst (.SYS_CLK(sys_clk),
    .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TRIGGER(trig), .FRAME_VALID(fv),
    .LINE_VALID(lv), .PIX_ROW(prow), .PIX_COL(pcol),
    .ALL_ROWS_RESET(allrst), .SHUT_ROW_VLD(svld), .SHUT_ROW(srow),
    .GAIN(gain));

  fec_host_model fec_host_model_inst (.clk(sys_clk), .fv(fv), .lv(lv),
    .row(prow), .col(pcol), .arm(arm), .trig(trig), .lines(lines),
    .pix(pix), .frow(frow), .fcol(fcol));

  // ==========================================================
  // shared tasks
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    check_count++;
    if (seen !== ex) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no wait count assumed; a hang ends at the watchdog
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w) exp_reg[a[5:2]] = d;
  endtask : apb

  task rchk(input string nm, input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp_reg[a[5:2]]);
  endtask : rchk

  task wait_fv(input logic v);
    while (fv !== v) @(posedge sys_clk);
  endtask : wait_fv

  // one whole frame; one more edge lets the host model latch it
  task frame;
    wait_fv(1'b1);
    wait_fv(1'b0);
    @(posedge sys_clk);
  endtask : frame

  // cycles from the first row release to frame valid
  task expo(output int n);
    wait_fv(1'b0);
    while (svld !== 1'b1) @(posedge sys_clk);
    chk("first_release", srow, {20'h0, ROW_START_RST});
    n = 0;
    while (fv !== 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : expo

  // ==========================================================
  // scenarios
  initial begin
    foreach (exp_reg[i]) exp_reg[i] = 32'h0;
    exp_reg[3] = {20'h0, COL_SIZE_RST};
    exp_reg[4] = {20'h0, ROW_SIZE_RST};
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk("all_rows_reset", allrst, 32'h1);
    rchk("col_size", ADDR_COL_SIZE);
    rchk("row_size", ADDR_ROW_SIZE);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped_err", err, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    $display("test defaults done");
    // odd sizes keep the window even
    apb(1'b1, ADDR_COL_SIZE, 32'h7);
    apb(1'b1, ADDR_ROW_SIZE, 32'h3);
    apb(1'b1, ADDR_CTRL, 32'h1);
    frame;
    chk("lines", lines, 32'd4);
    chk("pixels", pix, 32'd8);
    chk("first_row", frow, 32'h00C);
    chk("first_col", fcol, 32'h010);
    exp_reg[0] = 32'h0;
    rchk("ctrl", ADDR_CTRL);
    $display("test window done");
    // writes finish while frame valid is high
    wait_fv(1'b1);
    apb(1'b1, ADDR_ROW_SIZE, 32'h5);
    frame;
    chk("lines_same", lines, 32'd4);
    frame;
    chk("lines_next", lines, 32'd6);
    wait_fv(1'b1);
    apb(1'b1, ADDR_CTRL, 32'hC0);
    frame;
    frame;
    chk("mirror_row", frow, 32'h011);
    chk("mirror_col", fcol, 32'h017);
    $display("test sync and mirror done");
    g = 8'($random(seed));
    if (g == GAIN_RST) g = ~g;
    apb(1'b1, ADDR_CTRL, 32'hC4);
    apb(1'b1, ADDR_GAIN, {24'h0, g});
    frame;
    frame;
    chk("gain_held", gain, 32'h10);
    rchk("gain_reg", ADDR_GAIN);
    apb(1'b1, ADDR_CTRL, 32'hC0);
    frame;
    frame;
    chk("gain_free", gain, {24'h0, g});
    $display("test hold done");
    wait_fv(1'b1);
    apb(1'b1, ADDR_ROW_SIZE, 32'h3);
    apb(1'b1, ADDR_CTRL, 32'hC1);
    repeat (3) @(posedge sys_clk);
    chk("abort_fv", fv, 32'h0);
    frame;
    chk("restart_lines", lines, 32'd4);
    chk("restart_row", frow, 32'h00F);
    $display("test restart done");
    // 8-pixel window rows, width from reset, delay of 5
    apb(1'b1, ADDR_FINE_DELAY, 32'h5);
    expo(nexp);
    chk("exposure", nexp, EXP_WIDTH_RST * (8 + HBLANK_CYC) - 10);
    $display("test exposure done");
    apb(1'b1, ADDR_CTRL, 32'hC3);
    repeat (200) @(posedge sys_clk);
    chk("pause_fv", fv, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("pause_state", rd, 32'h6);
    apb(1'b1, ADDR_CTRL, 32'hC1);
    frame;
    chk("resume_lines", lines, 32'd4);
    exp_reg[0] = 32'hC0;
    rchk("ctrl_cleared", ADDR_CTRL);
    $display("test pause done");
    apb(1'b1, ADDR_CTRL, 32'hD8);
    repeat (1000) @(posedge sys_clk);
    chk("grr_idle_reset", allrst, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("snap_idle", rd, 32'h1);
    apb(1'b1, ADDR_ROW_SIZE, 32'h5);
    apb(1'b1, ADDR_TRIGGER, 32'h1);
    frame;
    chk("snap_lines", lines, 32'd6);
    apb(1'b1, ADDR_CTRL, 32'hC8);
    apb(1'b1, ADDR_TRIGGER, 32'h1);
    wait_fv(1'b1);
    arm <= 1'b1;
    frame;
    apb(1'b1, ADDR_ROW_SIZE, 32'h3);
    frame;
    chk("late_write_held", lines, 32'd6);
    frame;
    chk("late_write_next", lines, 32'd4);
    arm <= 1'b0;
    $display("test snapshot done");
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk("reset_again", allrst, 32'h1);
    chk("reset_fv", fv, 32'h0);
    $display("test reset done");
    report_and_stop;
  end

  // a hang is cut short well past the expected run time
  initial begin
    #400000;
    n_fail++;
    report_and_stop;
  end
endmodule : fec_core_tb_top
